// file: hw/edls_pkg.sv
package edls_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] RX_LIST_BASE_OFS = 8'h0C;
    localparam logic [7:0] TX_LIST_BASE_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
    localparam logic [7:0] CTRL_OFS = 8'h18;

    // Bus width select codes
    localparam logic [1:0] BUS_W32 = 2'h0;
    localparam logic [1:0] BUS_W64 = 2'h1;
    localparam logic [1:0] BUS_W128 = 2'h2;

    // Status field positions
    localparam int TS_FLAG_POS = 29;
    localparam int PM_FLAG_POS = 28;
    localparam int CNT_FLAG_POS = 27;
    localparam int BERR_LSB = 23;
    localparam int TXPS_LSB = 20;
    localparam int RXPS_LSB = 17;
    localparam int FATAL_POS = 13;
    localparam int NIS_POS = 16;
    localparam int AIS_POS = 15;

    // Event bit masks
    localparam logic [16:0] EVT_MASK = 17'h1_FFFF;
    localparam logic [16:0] NORMAL_SET = 17'h0_4045;
    localparam logic [16:0] ABNORMAL_SET = 17'h0_2FBA;

    // Reset values
    localparam logic [31:0] LIST_BASE_RST = 32'h0000_0000;
    localparam logic [16:0] EVT_RST = 17'h0_0000;
    localparam logic [2:0] BERR_RST = 3'h0;

    // Bus error type codes
    localparam logic [2:0] BERR_RX_DATA = 3'h0;
    localparam logic [2:0] BERR_TX_READ = 3'h3;
    localparam logic [2:0] BERR_RX_DWR = 3'h4;
    localparam logic [2:0] BERR_TX_DWR = 3'h5;
    localparam logic [2:0] BERR_RX_DRD = 3'h6;
    localparam logic [2:0] BERR_TX_DRD = 3'h7;

    typedef enum logic [2:0] {
        EDLS_BE_RX_DATA,
        EDLS_BE_TX_READ,
        EDLS_BE_RX_DWR,
        EDLS_BE_TX_DWR,
        EDLS_BE_RX_DRD,
        EDLS_BE_TX_DRD
    } edls_berr_src_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } edls_bus_req_t;

    typedef struct packed {
        logic ts;
        logic pm;
        logic cnt;
    } edls_sub_evt_t;

endpackage

// file: hw/edls_list_base.sv
`timescale 1ns/1ps
module edls_list_base (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [1:0] bus_width_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    input wire logic run_i,
    input wire logic [31:0] cur_addr_i,
    output logic [31:0] base_o,
    output logic [31:0] fetch_addr_o,
    output logic load_o
);
    logic [31:0] base_reg;
    logic [31:0] base_next;
    logic fresh_reg;
    logic fresh_next;
    logic run_reg;
    logic [31:0] resume_reg;
    logic [31:0] resume_next;
    logic [31:0] align_mask;
    logic start;

    assign align_mask = (bus_width_i == edls_pkg::BUS_W128) ? 32'hFFFF_FFF0 :
                        (bus_width_i == edls_pkg::BUS_W64) ? 32'hFFFF_FFF8 :
                        32'hFFFF_FFFC;
    assign base_o = base_reg & align_mask;
    assign start = run_i & ~run_reg;
    // Writes only accepted while stopped
    assign base_next = (wr_i && !run_i) ? wdata_i : base_reg;
    assign fresh_next = (wr_i && !run_i) ? 1'b1 : (start ? 1'b0 : fresh_reg);
    // Track current position while running, hold it when stopped
    assign resume_next = run_reg ? cur_addr_i : resume_reg;
    assign load_o = start;
    // New base if rewritten, else resume
    assign fetch_addr_o = fresh_reg ? base_o : resume_reg;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            base_reg <= edls_pkg::LIST_BASE_RST;
            fresh_reg <= 1'b1;
            run_reg <= 1'b0;
            resume_reg <= edls_pkg::LIST_BASE_RST;
        end else begin
            base_reg <= base_next;
            fresh_reg <= fresh_next;
            run_reg <= run_i;
            resume_reg <= resume_next;
        end
    end
endmodule // edls_list_base

// file: hw/edls_status.sv
`timescale 1ns/1ps
module edls_status (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [16:0] evt_set_i,
    input wire logic [16:0] w1c_i,
    input wire logic [16:0] mask_i,
    output logic [16:0] evt_o,
    output logic irq_o
);
    logic [16:0] evt_reg;
    logic [16:0] evt_next;
    logic [16:0] raw;
    logic [16:0] live;
    logic nis;
    logic ais;

    // Set wins over clear, summaries derived from enabled sources
    assign raw = (evt_reg & ~w1c_i) | evt_set_i;
    assign nis = |(raw & mask_i & edls_pkg::NORMAL_SET);
    assign ais = |(raw & mask_i & edls_pkg::ABNORMAL_SET);
    always_comb begin
        evt_next = raw;
        evt_next[edls_pkg::NIS_POS] = raw[edls_pkg::NIS_POS] | nis;
        evt_next[edls_pkg::AIS_POS] = raw[edls_pkg::AIS_POS] | ais;
    end
    assign live = evt_reg & mask_i;
    assign irq_o = |live;
    assign evt_o = evt_reg;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            evt_reg <= edls_pkg::EVT_RST;
        end else begin
            evt_reg <= evt_next & edls_pkg::EVT_MASK;
        end
    end
endmodule // edls_status

// file: hw/edls_top.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module edls_top (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    input wire logic [1:0] bus_width_i,
    input wire logic ts_enable_i,
    input wire logic pm_enable_i,
    input wire logic cnt_enable_i,
    input wire logic rx_start_bit_i,
    input wire logic tx_start_bit_i,
    input wire logic [31:0] rx_cur_addr_i,
    input wire logic [31:0] tx_cur_addr_i,
    input wire logic [16:0] evt_set_i,
    input wire logic berr_valid_i,
    input wire logic [2:0] berr_src_i,
    input wire logic timestamp_event_i,
    input wire logic power_mgmt_event_i,
    input wire logic counter_event_i,
    input wire logic [2:0] tx_process_state_i,
    input wire logic [2:0] rx_process_state_i,
    output logic [31:0] rx_fetch_addr_o,
    output logic rx_fetch_load_o,
    output logic [31:0] tx_fetch_addr_o,
    output logic tx_fetch_load_o
);
    edls_pkg::edls_bus_req_t req;
    edls_pkg::edls_sub_evt_t sub;
    logic [31:0] rx_list_start_address;
    logic [31:0] tx_list_start_address;
    logic [16:0] evt;
    logic [16:0] mask_reg;
    logic [16:0] mask_next;
    logic [2:0] bus_error_type_reg;
    logic [2:0] bus_error_type_next;
    logic [2:0] berr_code;
    logic [31:0] status_word;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] rd_mux;
    logic [16:0] w1c;
    logic [16:0] evt_set_all;
    logic sel_rx;
    logic sel_tx;
    logic sel_sts;
    logic sel_mask;
    logic sel_ctrl;
    logic irq_evt;
    logic rx_run;
    logic tx_run;
    logic [2:0] ts_sync_reg;
    logic [2:0] ts_meta_reg;

    function automatic logic [2:0] berr_encode(
        input logic [2:0] src
    );
        case (src)
            edls_pkg::EDLS_BE_RX_DATA: berr_encode = edls_pkg::BERR_RX_DATA;
            edls_pkg::EDLS_BE_TX_READ: berr_encode = edls_pkg::BERR_TX_READ;
            edls_pkg::EDLS_BE_RX_DWR: berr_encode = edls_pkg::BERR_RX_DWR;
            edls_pkg::EDLS_BE_TX_DWR: berr_encode = edls_pkg::BERR_TX_DWR;
            edls_pkg::EDLS_BE_RX_DRD: berr_encode = edls_pkg::BERR_RX_DRD;
            edls_pkg::EDLS_BE_TX_DRD: berr_encode = edls_pkg::BERR_TX_DRD;
            default: berr_encode = edls_pkg::BERR_RX_DATA;
        endcase
    endfunction

    assign req.addr = addr_i;
    assign req.wdata = wdata_i;
    assign req.wr = wr_i;
    assign req.rd = rd_i;

    assign sel_rx = req.addr == edls_pkg::RX_LIST_BASE_OFS;
    assign sel_tx = req.addr == edls_pkg::TX_LIST_BASE_OFS;
    assign sel_sts = req.addr == edls_pkg::STATUS_OFS;
    assign sel_mask = req.addr == edls_pkg::IRQ_MASK_OFS;
    assign sel_ctrl = req.addr == edls_pkg::CTRL_OFS;

    assign rx_run = rx_start_bit_i;
    assign tx_run = tx_start_bit_i;

    edls_list_base u_rx_base (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .bus_width_i(bus_width_i),
        .wr_i(req.wr & sel_rx),
        .wdata_i(req.wdata),
        .run_i(rx_run),
        .cur_addr_i(rx_cur_addr_i),
        .base_o(rx_list_start_address),
        .fetch_addr_o(rx_fetch_addr_o),
        .load_o(rx_fetch_load_o)
    );

    edls_list_base u_tx_base (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .bus_width_i(bus_width_i),
        .wr_i(req.wr & sel_tx),
        .wdata_i(req.wdata),
        .run_i(tx_run),
        .cur_addr_i(tx_cur_addr_i),
        .base_o(tx_list_start_address),
        .fetch_addr_o(tx_fetch_addr_o),
        .load_o(tx_fetch_load_o)
    );

    // Write-one-to-clear; reads never clear
    assign w1c = (req.wr && sel_sts) ? req.wdata[16:0] : 17'h0_0000;
    // Bus error always raises the fatal flag
    assign evt_set_all = evt_set_i |
        (17'(berr_valid_i) << edls_pkg::FATAL_POS);

    edls_status u_status (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .evt_set_i(evt_set_all),
        .w1c_i(w1c),
        .mask_i(mask_reg),
        .evt_o(evt),
        .irq_o(irq_evt)
    );

    assign mask_next = (req.wr && sel_mask) ? req.wdata[16:0] : mask_reg;
    assign berr_code = berr_encode(berr_src_i);
    // Latched on error; no interrupt of its own
    assign bus_error_type_next = berr_valid_i ? berr_code :
                                 bus_error_type_reg;

    // Sub-block flags are levels from outside, synchronised
    assign sub.ts = ts_sync_reg[0] & ts_enable_i;
    assign sub.pm = ts_sync_reg[1] & pm_enable_i;
    assign sub.cnt = ts_sync_reg[2] & cnt_enable_i;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[16:0] = evt;
        status_word[edls_pkg::TS_FLAG_POS] = sub.ts;
        status_word[edls_pkg::PM_FLAG_POS] = sub.pm;
        status_word[edls_pkg::CNT_FLAG_POS] = sub.cnt;
        status_word[edls_pkg::BERR_LSB +: 3] = bus_error_type_reg;
        status_word[edls_pkg::TXPS_LSB +: 3] = tx_process_state_i;
        status_word[edls_pkg::RXPS_LSB +: 3] = rx_process_state_i;
    end

    assign rd_mux = sel_rx ? rx_list_start_address :
                    sel_tx ? tx_list_start_address :
                    sel_sts ? status_word :
                    sel_mask ? {15'h0000, mask_reg} :
                    sel_ctrl ? {30'h0000_0000, bus_width_i} :
                    32'h0000_0000;
    assign rdata_next = req.rd ? rd_mux : 32'h0000_0000;
    assign rdata_o = rdata_reg;
    // Sub-block flags reach the line without mask
    assign irq_o = irq_evt | sub.ts | sub.pm | sub.cnt;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            mask_reg <= edls_pkg::EVT_RST;
            bus_error_type_reg <= edls_pkg::BERR_RST;
            rdata_reg <= 32'h0000_0000;
            ts_meta_reg <= 3'h0;
            ts_sync_reg <= 3'h0;
        end else begin
            mask_reg <= mask_next;
            bus_error_type_reg <= bus_error_type_next;
            rdata_reg <= rdata_next;
            ts_meta_reg <= {counter_event_i, power_mgmt_event_i,
                            timestamp_event_i};
            ts_sync_reg <= ts_meta_reg;
        end
    end
endmodule // edls_top

// file: tb/edls_checker.sv
`timescale 1ns/1ps
module edls_checker (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] bus_width_i,
    input wire logic ts_enable_i,
    input wire logic rx_start_bit_i,
    input wire logic tx_start_bit_i,
    input wire logic [16:0] evt_set_i,
    input wire logic berr_valid_i,
    input wire logic [2:0] berr_src_i,
    input wire logic [2:0] tx_process_state_i,
    input wire logic rx_fetch_load_o,
    input wire logic tx_fetch_load_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    wire logic st_rd = rd_i && addr_i == edls_pkg::STATUS_OFS;
    wire logic quiet = evt_set_i == 17'h0_0000 && !berr_valid_i;
    wire logic base_rd = rd_i && (addr_i == edls_pkg::RX_LIST_BASE_OFS ||
        addr_i == edls_pkg::TX_LIST_BASE_OFS);
    wire logic [3:0] lo_m = bus_width_i == edls_pkg::BUS_W32 ? 4'h3 :
        bus_width_i == edls_pkg::BUS_W64 ? 4'h7 : 4'hF;
    wire logic [2:0] ecode = berr_src_i == 3'h0 ? 3'h0 :
        berr_src_i == 3'h1 ? 3'h3 : berr_src_i + 3'h2;
    base_low_zero_a: assert property (base_rd |=>
        (rdata_o[3:0] & $past(lo_m)) == 4'h0) else $error("base low bits set");
    read_keeps_a: assert property (st_rd && quiet ##1 quiet && !wr_i
        ##1 st_rd |=> rdata_o[16:0] == $past(rdata_o[16:0], 2))
        else $error("status read changed bits");
    rx_load_a: assert property ($rose(rx_start_bit_i) |->
        rx_fetch_load_o ##1 !rx_fetch_load_o) else $error("rx load wrong");
    tx_load_a: assert property (tx_fetch_load_o |->
        $rose(tx_start_bit_i)) else $error("tx load without start");
    err_type_a: assert property (berr_valid_i ##1 st_rd && !berr_valid_i
        |=> rdata_o[25:23] == $past(ecode, 2) && rdata_o[13])
        else $error("bus error type wrong");
    tx_state_a: assert property (st_rd |=>
        rdata_o[22:20] == $past(tx_process_state_i))
        else $error("tx state wrong");
    resv_zero_a: assert property (st_rd |=>
        rdata_o[31:30] == 2'h0 && !rdata_o[26]) else $error("reserved set");
    ts_resv_a: assert property (st_rd && !ts_enable_i |=>
        !rdata_o[29]) else $error("timestamp flag while disabled");
endmodule // edls_checker
bind edls_top edls_checker i_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .bus_width_i(bus_width_i), .ts_enable_i(ts_enable_i),
    .rx_start_bit_i(rx_start_bit_i), .tx_start_bit_i(tx_start_bit_i),
    .evt_set_i(evt_set_i), .berr_valid_i(berr_valid_i),
    .berr_src_i(berr_src_i), .tx_process_state_i(tx_process_state_i),
    .rx_fetch_load_o(rx_fetch_load_o), .tx_fetch_load_o(tx_fetch_load_o));

// file: tb/edls_mem_model.sv
`timescale 1ns/1ps
module edls_mem_model (
    input wire logic mclk_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [31:0] start_i,
    output logic [31:0] cur_o
);
    initial cur_o = 32'h0000_0000;
    // Descriptor walk, steps on rising edge
    always @(posedge mclk_i) begin
        if (load_i) begin
            cur_o <= start_i;
        end else if (run_i) begin
            cur_o <= cur_o + 32'h0000_0010;
        end
    end
endmodule // edls_mem_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, bv = 0, irq;
    logic [7:0] addr = 0, o;
    logic [31:0] wdata = 0, rdata, b, e, x;
    logic [1:0] bw = 0, run = 0;
    wire logic [1:0] ld;
    logic [2:0] en = 0, sub = 0, bsrc = 0, txs = 0, rxs = 0;
    logic [16:0] evt = 0, v;
    wire logic [31:0] cur[2], fa[2];
    logic [2:0] codes[6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    int fail_count = 0, n_compared = 0, cyc = 0;
    localparam logic [7:0] ST = edls_pkg::STATUS_OFS;
    edls_top i_dut (.mclk_i(clk), .nrst_i(rst_n), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .irq_o(irq), .bus_width_i(bw), .ts_enable_i(en[2]),
        .pm_enable_i(en[1]), .cnt_enable_i(en[0]),
        .rx_start_bit_i(run[0]), .tx_start_bit_i(run[1]),
        .rx_cur_addr_i(cur[0]), .tx_cur_addr_i(cur[1]), .evt_set_i(evt),
        .berr_valid_i(bv), .berr_src_i(bsrc), .timestamp_event_i(sub[2]),
        .power_mgmt_event_i(sub[1]), .counter_event_i(sub[0]),
        .tx_process_state_i(txs), .rx_process_state_i(rxs),
        .rx_fetch_addr_o(fa[0]), .rx_fetch_load_o(ld[0]),
        .tx_fetch_addr_o(fa[1]), .tx_fetch_load_o(ld[1]));
    for (genvar g = 0; g < 2; g++) begin : g_mem
        edls_mem_model i_mem (.mclk_i(clk), .run_i(run[g]), .load_i(ld[g]),
            .start_i(fa[g]), .cur_o(cur[g]));
    end
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(string n, logic [31:0] ex, logic [31:0] got);
        n_compared++;
        if (ex !== got) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, ex, got);
        end
    endtask
    task automatic wrt(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(string n, logic [7:0] a, logic [31:0] ex,
        logic [31:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(n, ex & m, rdata & m);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        b = $urandom(63);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdc("rx base rst", edls_pkg::RX_LIST_BASE_OFS, 0, '1);
        rdc("tx base rst", edls_pkg::TX_LIST_BASE_OFS, 0, '1);
        rdc("status rst", ST, 0, '1);
        rdc("unmapped", 8'h40, 0, '1);
        for (int w = 0; w < 3; w++) begin
            @(posedge clk);
            bw <= w[1:0];
            b = $urandom;
            e = b & ~((32'h4 << w) - 1);
            x = ~b & ~((32'h4 << w) - 1);
            wrt(edls_pkg::RX_LIST_BASE_OFS, b);
            wrt(edls_pkg::TX_LIST_BASE_OFS, ~b);
            rdc("rx mask", edls_pkg::RX_LIST_BASE_OFS, e, '1);
            rdc("tx mask", edls_pkg::TX_LIST_BASE_OFS, x, '1);
        end
        $display("test base done");
        @(posedge clk);
        bw <= 2'h0;
        for (int c = 0; c < 2; c++) begin
            o = c ? edls_pkg::TX_LIST_BASE_OFS : edls_pkg::RX_LIST_BASE_OFS;
            b = $urandom;
            e = b & ~32'h3;
            wrt(o, b);
            @(posedge clk);
            run[c] <= 1'b1;
            @(negedge clk);
            chk("load", 1, 32'(ld[c]));
            chk("start addr", e, fa[c]);
            repeat (5) @(posedge clk);
            wrt(o, ~b);
            rdc("held base", o, e, '1);
            @(posedge clk);
            run[c] <= 1'b0;
            repeat (2) @(posedge clk);
            x = cur[c];
            run[c] <= 1'b1;
            @(negedge clk);
            chk("resume addr", x, fa[c]);
            @(posedge clk);
            run[c] <= 1'b0;
        end
        $display("test start done");
        v = 17'($urandom & 32'h0001_9000) | 17'h0_1000;
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 17'h0_0000;
        rdc("status", ST, {15'h0, v}, 32'h0001_FFFF);
        rdc("status again", ST, {15'h0, v}, 32'h0001_FFFF);
        chk("irq masked", 0, 32'(irq));
        wrt(edls_pkg::IRQ_MASK_OFS, 32'h0000_1000);
        @(negedge clk);
        chk("irq on", 1, 32'(irq));
        wrt(ST, 32'h0000_1000);
        rdc("w1c", ST, {15'h0, v & 17'h1_8000}, 32'h0001_FFFF);
        chk("irq off", 0, 32'(irq));
        wrt(ST, '1);
        wrt(edls_pkg::IRQ_MASK_OFS, 32'h0001_DFFF);
        $display("test events done");
        for (int s = 0; s < 6; s++) begin
            @(posedge clk);
            bsrc <= s[2:0];
            bv <= 1'b1;
            @(posedge clk);
            bv <= 1'b0;
            addr <= ST;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            chk("err type", {6'h0, codes[s], 23'h2000},
                rdata & 32'h0380_2000);
            chk("err irq", 0, 32'(irq));
        end
        $display("test errors done");
        wrt(ST, '1);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            en <= i[2:0];
            sub <= {3{i[3]}};
            txs <= 3'($urandom);
            rxs <= 3'($urandom);
            repeat (4) @(posedge clk);
            e = {2'b00, en & sub, 1'b0, 3'b000, txs, rxs, 17'h0};
            rdc("flags", ST, e, 32'hFC7E_0000);
            chk("flag irq", 32'(|(en & sub)), 32'(irq));
        end
        $display("test flags done");
        test_done();
    end
endmodule // tb_top
